//--- src/bus_interrupt_vector_routing.sv
`timescale 1ns/1ps
// Behaviour
// - eight request inputs, each individually maskable
// - lowest unmasked active input served first
// - answer with three-byte call over reads
// - input zero first entry, 4/8 byte steps
// - registers only at offsets 4, 5, group 0
// - inputs wired: vectored, serial, printer, clock
// - offset 4 with bit 4 starts init
// - word one: flags low, address bits 5-7
// - offset 5 is word two only after one
// - jumper linked: master drives call opcode and address
// - jumper grounded: never drive vector bytes
// - vector gating never blocks request outputs
// - master routes request to general line
// - slave without cascade cable drives its own vectored line
// - slave ignores vectored-line inputs
// - cascade cable carries one slave's request
// - cascade: three id lines plus request
// - master request pulls general line low
// - first acknowledge outputs call opcode
// - master with jumper linked asserts address disable from acknowledge until third read
module bus_interrupt_vector_routing
  import irq_route_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [2:0] i_io_offset,
  input wire logic [1:0] i_group,
  input wire logic i_ctrl_enable,
  input wire logic [7:0] i_wr_data,
  input wire logic i_mem_rd,
  input wire logic i_int_ack,
  input wire logic [2:0] i_vectored_in,
  input wire logic [2:0] i_serial_device_irq,
  input wire logic i_print_wheel_ready,
  input wire logic i_clock_timed_pulse,
  input wire logic i_is_master,
  input wire logic [1:0] i_slave_line,
  input wire logic i_vector_gating_jumper,
  input wire logic i_request_routing_pads,
  input wire logic i_cascade_cable,
  input wire logic [1:0] i_cascade_input,
  input wire logic i_cascade_req,
  input wire logic [2:0] i_cascade_id_in,
  output logic o_pint_n,
  output logic [2:0] o_vectored_out_n,
  output logic [2:0] o_cascade_id,
  output logic o_cascade_id_oe,
  output logic o_cascade_req,
  output logic o_addr_disable,
  output logic [7:0] o_data_in,
  output logic o_data_oe,
  output logic o_int_pending
);
  import irq_route_pkg::*;

  logic [7:0] raw_s1_q;
  logic [7:0] raw_s2_q;
  logic [2:0] cas_s1_q;
  logic [2:0] cas_s2_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_prev_q;
  logic rd_s1_q;
  logic rd_s2_q;
  logic rd_prev_q;
  logic [7:0] mask_q;
  logic [7:0] init_one_q;
  logic [7:0] init_two_q;
  logic expect_two_q;
  logic ready_q;
  ack_state_e ack_state_q;
  logic [2:0] served_q;
  logic [15:0] call_addr_q;
  logic [1:0] bytes_left_q;
  logic [7:0] data_q;
  logic drive_q;
  logic [7:0] raw_req;
  logic [7:0] live_req;
  logic any_req;
  logic [2:0] pick_idx;
  logic sel_cmd;
  logic sel_data;
  logic ack_rise;
  logic rd_rise;

  function automatic logic [15:0] call_address(input logic [7:0] one, input logic [7:0] two,
                                               input logic [2:0] n);
    logic [15:0] base;
    base = {two, one[7:5], 5'h00};
    if (one[SPACING_FLAG_BIT]) begin
      call_address = base | {11'h000, n, 2'h0};
    end else begin
      call_address = {base[15:6], 6'h00} | {10'h000, n, 3'h0};
    end
  endfunction : call_address

  always_comb begin
    raw_req[2:0] = i_vectored_in;
    raw_req[5:3] = i_serial_device_irq;
    raw_req[6] = i_print_wheel_ready;
    raw_req[7] = i_clock_timed_pulse;
    if (i_cascade_cable && i_is_master && i_cascade_input != 2'h3) begin
      raw_req[i_cascade_input] = i_cascade_req;
    end
  end

  // pins are asynchronous to the clock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      raw_s1_q <= 8'h00;
      raw_s2_q <= 8'h00;
      cas_s1_q <= 3'h0;
      cas_s2_q <= 3'h0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
    end else begin
      raw_s1_q <= raw_req;
      raw_s2_q <= raw_s1_q;
      cas_s1_q <= i_cascade_id_in;
      cas_s2_q <= cas_s1_q;
      ack_s1_q <= i_int_ack;
      ack_s2_q <= ack_s1_q;
      rd_s1_q <= i_mem_rd;
      rd_s2_q <= rd_s1_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      ack_prev_q <= ack_s2_q;
      rd_prev_q <= rd_s2_q;
    end
  end

  assign ack_rise = ack_s2_q && !ack_prev_q;
  assign rd_rise = rd_s2_q && !rd_prev_q;

  assign sel_cmd = i_ctrl_enable && i_group == GROUP_PIC && i_io_offset == OFS_CMD;
  assign sel_data = i_ctrl_enable && i_group == GROUP_PIC && i_io_offset == OFS_DATA;

  always_comb begin
    live_req = raw_s2_q & ~mask_q;
    if (!i_is_master) begin
      live_req[2:0] = 3'h0;
    end
    if (!ready_q) begin
      live_req = 8'h00;
    end
  end

  irq_priority_pick #(
    .WIDTH(NUM_INPUTS)
  ) u_pick (
    .i_req(live_req),
    .o_any(any_req),
    .o_index(pick_idx)
  );

  // init word sequencing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      init_one_q <= INIT_ONE_RESET;
      init_two_q <= INIT_TWO_RESET;
      expect_two_q <= 1'b0;
      ready_q <= 1'b0;
      mask_q <= MASK_RESET;
    end else if (i_io_wr && sel_cmd && i_wr_data[INIT_FLAG_BIT]) begin
      init_one_q <= i_wr_data;
      expect_two_q <= 1'b1;
      ready_q <= 1'b0;
      mask_q <= MASK_RESET;
    end else if (i_io_wr && sel_data) begin
      if (expect_two_q) begin
        init_two_q <= i_wr_data;
        ready_q <= 1'b1;
      end else begin
        mask_q <= i_wr_data;
      end
      expect_two_q <= 1'b0;
    end else if ((i_io_wr || i_io_rd) && (sel_cmd || sel_data)) begin
      // any other access breaks the pairing
      expect_two_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_state_q <= ACK_IDLE;
      served_q <= 3'h0;
      call_addr_q <= 16'h0000;
      bytes_left_q <= 2'h0;
      data_q <= 8'h00;
      drive_q <= 1'b0;
    end else begin
      case (ack_state_q)
        ACK_IDLE: begin
          drive_q <= 1'b0;
          if (ack_rise && any_req) begin
            served_q <= pick_idx;
            call_addr_q <= call_address(init_one_q, init_two_q, pick_idx);
            bytes_left_q <= VEC_BYTES;
            data_q <= CALL_OPCODE;
            drive_q <= i_is_master && i_vector_gating_jumper;
            ack_state_q <= ACK_LOW;
          end
        end
        ACK_LOW: begin
          if (rd_rise) begin
            data_q <= call_addr_q[7:0];
            bytes_left_q <= bytes_left_q - 2'h1;
            ack_state_q <= ACK_HIGH;
          end
        end
        ACK_HIGH: begin
          if (rd_rise) begin
            if (bytes_left_q == 2'h2) begin
              data_q <= call_addr_q[15:8];
              bytes_left_q <= bytes_left_q - 2'h1;
            end else begin
              bytes_left_q <= 2'h0;
              drive_q <= 1'b0;
              ack_state_q <= ACK_IDLE;
            end
          end
        end
        default: begin
          ack_state_q <= ACK_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  assign o_addr_disable = (ack_state_q != ACK_IDLE) && i_is_master && i_vector_gating_jumper;
  assign o_data_in = data_q;
  assign o_data_oe = drive_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pint_n <= 1'b1;
      o_vectored_out_n <= 3'h7;
      o_cascade_req <= 1'b0;
      o_int_pending <= 1'b0;
    end else begin
      o_int_pending <= any_req;
      o_pint_n <= !(i_request_routing_pads && i_is_master && any_req);
      o_vectored_out_n <= 3'h7;
      if (i_request_routing_pads && !i_is_master && !i_cascade_cable && any_req
          && i_slave_line != 2'h3) begin
        o_vectored_out_n[i_slave_line] <= 1'b0;
      end
      o_cascade_req <= i_request_routing_pads && !i_is_master && i_cascade_cable && any_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cascade_id <= 3'h0;
      o_cascade_id_oe <= 1'b0;
    end else begin
      o_cascade_id <= served_q;
      o_cascade_id_oe <= i_is_master && ack_state_q != ACK_IDLE;
    end
  end

  logic unused_cas;
  assign unused_cas = ^cas_s2_q;
endmodule : bus_interrupt_vector_routing

//--- src/irq_route_pkg.sv
package irq_route_pkg;
  localparam int unsigned NUM_INPUTS = 8;
  localparam logic [2:0] OFS_CMD = 3'h4;
  localparam logic [2:0] OFS_DATA = 3'h5;
  localparam logic [1:0] GROUP_PIC = 2'h0;
  localparam int unsigned INIT_FLAG_BIT = 4;
  localparam int unsigned SPACING_FLAG_BIT = 2;
  localparam logic [7:0] CALL_OPCODE = 8'hcd;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] INIT_ONE_RESET = 8'h00;
  localparam logic [7:0] INIT_TWO_RESET = 8'h00;
  localparam logic [1:0] VEC_BYTES = 2'h3;
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_LOW = 2'b01,
    ACK_HIGH = 2'b10
  } ack_state_e;
endpackage : irq_route_pkg

//--- src/irq_priority_pick.sv
`timescale 1ns/1ps
module irq_priority_pick #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] i_req,
  output logic o_any,
  output logic [2:0] o_index
);
  // lowest index wins
  always_comb begin
    o_any = 1'b0;
    o_index = 3'h0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_any = 1'b1;
        o_index = 3'(i);
      end
    end
  end
endmodule : irq_priority_pick

//--- tb/irq_route_properties.sv
`timescale 1ns/1ps
module irq_route_properties
  import irq_route_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_int_ack,
  input wire logic i_is_master,
  input wire logic i_vector_gating_jumper,
  input wire logic o_pint_n,
  input wire logic [2:0] o_vectored_out_n,
  input wire logic o_addr_disable,
  input wire logic [7:0] o_data_in,
  input wire logic o_data_oe,
  input wire logic o_cascade_id_oe
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ack taken only while a linked master is requesting
  sequence s_ack;
    $rose(i_int_ack) && !o_pint_n && i_is_master && i_vector_gating_jumper;
  endsequence
  property p_ack; s_ack |-> ##[2:6] $rose(o_data_oe); endproperty
  a_ack: assert property (p_ack)
    else $error("no answer to ack");
  property p_op; $rose(o_data_oe) |-> o_data_in == CALL_OPCODE; endproperty
  a_op: assert property (p_op)
    else $error("first byte not opcode");
  property p_gnd; !i_vector_gating_jumper |-> !o_data_oe && !o_addr_disable; endproperty
  a_gnd: assert property (p_gnd)
    else $error("vector driven while grounded");
  property p_mst; o_data_oe |-> i_is_master; endproperty
  a_mst: assert property (p_mst)
    else $error("slave drives vector");
  property p_ad; $rose(o_data_oe) |-> o_addr_disable; endproperty
  a_ad: assert property (p_ad)
    else $error("no address disable");
  property p_pint; !o_pint_n |-> i_is_master; endproperty
  a_pint: assert property (p_pint)
    else $error("slave on general line");
  property p_vsl; o_vectored_out_n != 3'h7 |-> !i_is_master; endproperty
  a_vsl: assert property (p_vsl)
    else $error("master on vectored line");
  property p_one; $onehot0(~o_vectored_out_n); endproperty
  a_one: assert property (p_one)
    else $error("several vectored lines");
  property p_cid; $rose(o_data_oe) |=> o_cascade_id_oe; endproperty
  a_cid: assert property (p_cid)
    else $error("cascade id not driven");
endmodule : irq_route_properties

//--- tb/bus_cpu_model.sv
`timescale 1ns/1ps
module bus_cpu_model (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_pint_n,
  input wire logic [7:0] i_data,
  input wire logic i_oe,
  output logic o_ack,
  output logic o_rd,
  output logic [23:0] o_call,
  output int o_calls
);
  initial begin
    o_ack = 1'h0;
    o_rd = 1'h0;
    o_call = 24'h0;
    o_calls = 0;
    forever begin
      @(posedge i_clk);
      #1;
      if (i_en && i_pint_n === 1'h0) begin
        for (int k = 0; k < 4; k++) begin
          if (k == 0) o_ack = 1'h1;
          else o_rd = 1'h1;
          repeat (8) @(posedge i_clk);
          // undriven data lines float up to ones
          if (k < 3) o_call = {o_call[15:0], i_oe ? i_data : 8'hff};
          #1;
          o_ack = 1'h0;
          o_rd = 1'h0;
          repeat (2) @(posedge i_clk);
          #1;
        end
        o_calls++;
        repeat (4) @(posedge i_clk);
      end
    end
  end
endmodule : bus_cpu_model

//--- tb/bus_interrupt_vector_routing_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module bus_interrupt_vector_routing_tb;
  import irq_route_pkg::*;
  logic clk = 0, rst = 1, wr = 0, en = 1, mst = 1, jmp = 1, cab = 0, ce = 0, rdio = 0;
  logic [2:0] ofs = 0;
  logic [1:0] grp = 0, sl = 3;
  logic [7:0] wd = 0, rq = 0, dq;
  logic pn, cr, ad, oe, ack, rd, ip;
  logic [2:0] vn, cid;
  logic [23:0] call;
  int calls, n_fail = 0, tests_run = 0, cyc = 0;
  bus_interrupt_vector_routing u_bus_interrupt_vector_routing (
    .i_clk(clk), .i_rst(rst), .i_io_wr(wr), .i_io_rd(rdio), .i_io_offset(ofs),
    .i_group(grp), .i_ctrl_enable(en), .i_wr_data(wd), .i_mem_rd(rd), .i_int_ack(ack),
    .i_vectored_in(rq[2:0]), .i_serial_device_irq(rq[5:3]), .i_print_wheel_ready(rq[6]),
    .i_clock_timed_pulse(rq[7]), .i_is_master(mst), .i_slave_line(sl),
    .i_vector_gating_jumper(jmp), .i_request_routing_pads(1'h1), .i_cascade_cable(cab),
    .i_cascade_input(2'h3), .i_cascade_req(1'h0), .i_cascade_id_in(3'h0),
    .o_pint_n(pn), .o_vectored_out_n(vn), .o_cascade_id(cid), .o_cascade_id_oe(),
    .o_cascade_req(cr), .o_addr_disable(ad), .o_data_in(dq), .o_data_oe(oe),
    .o_int_pending(ip));
  bus_cpu_model u_bus_cpu_model (.i_clk(clk), .i_en(ce), .i_pint_n(pn), .i_data(dq),
    .i_oe(oe), .o_ack(ack), .o_rd(rd), .o_call(call), .o_calls(calls));
  initial forever #2 clk = ~clk;
  task automatic give_verdict();
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // idle cycle after each write keeps strobes apart
  task automatic put(input logic [2:0] o, input logic [7:0] d);
    ofs = o;
    wd = d;
    wr = 1'h1;
    @(posedge clk);
    #1;
    wr = 1'h0;
    @(posedge clk);
    #1;
  endtask : put
  // one-cycle read strobe on a controller offset
  task automatic peek(input logic [2:0] o);
    ofs = o;
    rdio = 1'h1;
    @(posedge clk);
    #1;
    rdio = 1'h0;
    @(posedge clk);
    #1;
  endtask : peek
  task automatic serve(input logic [7:0] r, input logic [23:0] e);
    int c0;
    c0 = calls;
    rq = r;
    ce = 1'h1;
    for (int i = 0; i < 200 && calls == c0; i++) @(posedge clk);
    #1;
    ce = 1'h0;
    rq = 8'h0;
    `CHK(calls, c0 + 1)
    `CHK(call, e)
    repeat (10) @(posedge clk);
    #1;
  endtask : serve
  task automatic watch(input logic [7:0] r);
    rq = r;
    repeat (12) @(posedge clk);
    #1;
  endtask : watch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'h0;
    put(OFS_CMD, 8'h9f);
    put(OFS_DATA, 8'hc1);
    serve(8'hc8, {CALL_OPCODE, 8'h8c, 8'hc1});
    `CHK(cid, 3'h3)
    for (int k = 0; k < 8; k++) serve(8'h01 << k, {CALL_OPCODE, 8'h80 + 8'(4 * k), 8'hc1});
    put(OFS_DATA, 8'h08);
    serve(8'hc8, {CALL_OPCODE, 8'h98, 8'hc1});
    grp = 2'h1;
    put(OFS_DATA, 8'hff);
    grp = 2'h0;
    en = 1'h0;
    put(OFS_DATA, 8'hff);
    en = 1'h1;
    serve(8'h40, {CALL_OPCODE, 8'h98, 8'hc1});
    put(OFS_DATA, 8'hff);
    watch(8'h01);
    `CHK(pn, 1'h1)
    watch(8'h00);
    put(OFS_CMD, 8'h9f);
    peek(OFS_CMD);
    put(OFS_DATA, 8'h00);
    watch(8'h08);
    `CHK(pn, 1'h1)
    `CHK(ip, 1'h0)
    watch(8'h00);
    put(OFS_CMD, 8'h5a);
    put(OFS_DATA, 8'h12);
    serve(8'h04, {CALL_OPCODE, 8'h50, 8'h12});
    jmp = 1'h0;
    serve(8'h02, 24'hffffff);
    jmp = 1'h1;
    mst = 1'h0;
    sl = 2'h1;
    watch(8'h08);
    `CHK(vn, 3'h5)
    `CHK(ip, 1'h1)
    `CHK(pn, 1'h1)
    watch(8'h01);
    `CHK(vn, 3'h7)
    cab = 1'h1;
    watch(8'h08);
    `CHK(cr, 1'h1)
    `CHK(vn, 3'h7)
    give_verdict();
  end
endmodule : bus_interrupt_vector_routing_tb
bind bus_interrupt_vector_routing irq_route_properties u_irq_route_properties (
  .i_clk(i_clk), .i_rst(i_rst), .i_int_ack(i_int_ack), .i_is_master(i_is_master),
  .i_vector_gating_jumper(i_vector_gating_jumper), .o_pint_n(o_pint_n),
  .o_vectored_out_n(o_vectored_out_n), .o_addr_disable(o_addr_disable),
  .o_data_in(o_data_in), .o_data_oe(o_data_oe), .o_cascade_id_oe(o_cascade_id_oe));
